// ### aal_alu.sv
// result and condition flag logic of the accumulator datapath
`timescale 1ns/100ps
module aal_alu
  import aal_pkg::*;
#(
  parameter int W = DATA_W
) (
  // operation and operands
  input  wire aal_op_t         op,
  input  wire logic [W-1:0]    a,
  input  wire logic [W-1:0]    m,
  input  wire logic [FLG_W-1:0] flags_in,
  // result
  output logic [W-1:0]         res,
  output logic [FLG_W-1:0]     flags_out
);
  logic cin;
  always_comb begin
    cin = (op == OP_ADC) & flags_in[FLG_C]; // [RL8] [RL9]
    res = a;
    flags_out = flags_in;
    case (op)
      OP_ADD, OP_ADC: begin
        res = a + m + W'(cin);
        flags_out[FLG_H] = (a[HALF_BIT] & m[HALF_BIT]) | (m[HALF_BIT] & ~res[HALF_BIT]) |
                           (~res[HALF_BIT] & a[HALF_BIT]); // [RL2]
        flags_out[FLG_V] = (a[W-1] & m[W-1] & ~res[W-1]) |
                           (~a[W-1] & ~m[W-1] & res[W-1]); // [RL5]
        flags_out[FLG_C] = (a[W-1] & m[W-1]) | (m[W-1] & ~res[W-1]) |
                           (~res[W-1] & a[W-1]); // [RL6]
      end
      OP_AND: begin
        res = a & m;
        flags_out[FLG_V] = 1'h0; // [RL10]
      end
      OP_SHL: begin
        res = {a[W-2:0], 1'h0};
        flags_out[FLG_C] = a[W-1]; // [RL12]
      end
      OP_ASR: begin
        res = {a[W-1], a[W-1:1]};
        flags_out[FLG_C] = a[0]; // [RL15]
      end
      default: res = a;
    endcase
    if (op != OP_NONE) begin
      flags_out[FLG_N] = res[W-1]; // [RL3]
      flags_out[FLG_Z] = ~|res; // [RL4]
    end
    if (op == OP_SHL || op == OP_ASR) begin
      flags_out[FLG_V] = flags_out[FLG_N] ^ flags_out[FLG_C]; // [RL13]
    end
  end
endmodule : aal_alu

// ### aal_core.sv
// accumulator add, logic and shift datapath with its register slave
//
// Behaviour
// RL1: flags hold carry 0, overflow 1, zero 2, negative 3, mask 4, half carry 5.
// RL2: additions set half carry on a carry out of bit 3.
// RL3: negative flag equals result bit 7.
// RL4: zero flag set exactly when the eight result bits are zero.
// RL5: additions set overflow when like-signed operands give an unlike-signed result.
// RL6: additions set carry on a carry out of bit 7.
// RL7: acc_sum_op 1B adds second to first accumulator, one byte, two cycles.
// RL8: sum_with_carry_op adds operand and carry flag into chosen accumulator.
// RL9: sum_no_carry_op adds operand into chosen accumulator, ignoring carry.
// RL10: bitwise_conj_op ANDs, clears overflow, keeps carry and half carry.
// RL11: dual operand modes take 2/2, 2/3, 3/4, 2/5 bytes and cycles.
// RL12: shift_left_op shifts up, zero into bit 0, old bit 7 to carry.
// RL13: after a shift, overflow equals negative xor carry.
// RL14: shift_left_op 48, 58 two cycles; 78 six cycles; 68 seven cycles.
// RL15: shift_right_signed_op shifts down, keeps bit 7, old bit 0 to carry.
// RL16: second operand byte sits at first byte address plus one.
// RL17: branch displacement is the signed second instruction byte.
// RL18: xreg_pointer and program_counter are sixteen bits with two bytes each.
// RL19: two eight-bit accumulators, the opcode selects which one.
// RL20: decoder takes accumulator and mode from the first byte.
// RL21: flags and destination are written together in the final cycle.
`timescale 1ns/100ps
module aal_core
  import aal_pkg::*;
#(
  parameter int W = DATA_W
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // execution state
  output logic             exec_busy
);
  typedef struct packed {
    aal_bus_t             bus;
    logic [ADDR_W-1:0]    idx;
    logic                 wr_ok;
    aal_exe_t             exe;
    logic [2:0]           cnt;
    logic [W-1:0]         acc1;
    logic [W-1:0]         acc2;
    logic [W-1:0]         operand;
    logic [W-1:0]         mem_res;
    logic [7:0]           cmd;
    logic [FLG_W-1:0]     flags;
    logic                 illegal;
    logic [15:0]          opbytes;
    logic [15:0]          xreg;
    logic [15:0]          pc;
    logic [31:0]          rdata;
  } aal_state_t;

  aal_state_t st_r;
  aal_state_t st_nxt;

  logic             addr_ok;
  logic             issue;
  logic             commit;
  logic [7:0]       dec_opc;
  logic             dec_valid;
  aal_op_t          dec_op;
  logic             dec_acc_b;
  logic             dec_use_acc2;
  aal_mode_t        dec_mode;
  logic             dec_to_mem;
  logic [1:0]       dec_bytes;
  logic [2:0]       dec_cycles;
  logic [W-1:0]     alu_a;
  logic [W-1:0]     alu_m;
  logic [W-1:0]     alu_res;
  logic [FLG_W-1:0] alu_flags;
  logic [15:0]      ea;
  logic [15:0]      ea_next;
  logic [15:0]      br_target;
  logic [31:0]      status_word;
  logic [31:0]      rd_mux;

  // request taken in the address phase
  assign addr_ok = hsel & hready & htrans[HTRANS_ACT] & (haddr[31:ADDR_W] == '0);
  assign issue = (st_r.bus == BUS_WR) && st_r.wr_ok && (st_r.idx == REG_CMD) &&
                 (st_r.exe == EXE_IDLE);
  assign commit = (st_r.exe == EXE_RUN) && (st_r.cnt == CYC_LAST);
  assign dec_opc = issue ? hwdata[7:0] : st_r.cmd;

  aal_decode u_decode (
    .opc      (dec_opc),
    .valid    (dec_valid),
    .op       (dec_op),
    .acc_b    (dec_acc_b),
    .use_acc2 (dec_use_acc2),
    .mode     (dec_mode),
    .to_mem   (dec_to_mem),
    .nbytes   (dec_bytes),
    .ncycles  (dec_cycles)
  );

  // operand selection by accumulator designation
  assign alu_a = dec_to_mem ? st_r.operand : (dec_acc_b ? st_r.acc2 : st_r.acc1); // [RL19]
  assign alu_m = dec_use_acc2 ? st_r.acc2 : st_r.operand; // [RL7]

  aal_alu #(
    .W (W)
  ) u_alu (
    .op        (dec_op),
    .a         (alu_a),
    .m         (alu_m),
    .flags_in  (st_r.flags),
    .res       (alu_res),
    .flags_out (alu_flags)
  );

  // effective address of the memory operand
  always_comb begin
    case (dec_mode)
      MD_IMM: ea = st_r.pc + NEXT_BYTE;
      MD_DIR: ea = {PAGE_ZERO, st_r.opbytes[15:8]};
      MD_IND: ea = st_r.xreg + {PAGE_ZERO, st_r.opbytes[15:8]};
      MD_EXT: ea = st_r.opbytes;
      default: ea = WORD16_RST;
    endcase
  end
  assign ea_next = ea + NEXT_BYTE; // [RL16]
  assign br_target = st_r.pc + BRANCH_STEP +
                     {{8{st_r.opbytes[15]}}, st_r.opbytes[15:8]}; // [RL17]

  // read data selection
  always_comb begin
    status_word = WORD_ZERO;
    status_word[ST_BUSY] = (st_r.exe == EXE_RUN);
    status_word[ST_ILLEGAL] = st_r.illegal;
    status_word[ST_CYC_LSB +: 3] = dec_cycles;
    status_word[ST_LEN_LSB +: 2] = dec_bytes;
    case (st_r.idx)
      REG_ACC1: rd_mux = 32'(st_r.acc1);
      REG_ACC2: rd_mux = 32'(st_r.acc2);
      REG_FLAGS: rd_mux = 32'(st_r.flags);
      REG_OPERAND: rd_mux = 32'(st_r.operand);
      REG_CMD: rd_mux = 32'(st_r.cmd);
      REG_STATUS: rd_mux = status_word;
      REG_MEMRES: rd_mux = 32'(st_r.mem_res);
      REG_XREG: rd_mux = 32'(st_r.xreg);
      REG_PC: rd_mux = 32'(st_r.pc);
      REG_OPBYTES: rd_mux = 32'(st_r.opbytes);
      REG_EA: rd_mux = {ea_next, ea};
      REG_BRANCH: rd_mux = 32'(br_target);
      default: rd_mux = WORD_ZERO;
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    if (st_r.bus == BUS_RD_WAIT) begin
      st_nxt.rdata = rd_mux;
      st_nxt.bus = BUS_RD_DONE;
    end else begin
      st_nxt.bus = BUS_IDLE;
      if (addr_ok) begin
        st_nxt.idx = haddr[ADDR_W-1:0];
        st_nxt.wr_ok = hwrite && (hsize == SIZE_WORD);
        st_nxt.bus = hwrite ? BUS_WR : BUS_RD_WAIT;
      end
    end
    // register writes land only while no instruction runs
    if (st_r.bus == BUS_WR && st_r.wr_ok && st_r.exe == EXE_IDLE) begin
      case (st_r.idx)
        REG_ACC1: st_nxt.acc1 = hwdata[W-1:0];
        REG_ACC2: st_nxt.acc2 = hwdata[W-1:0];
        REG_FLAGS: st_nxt.flags = hwdata[FLG_W-1:0]; // [RL1]
        REG_OPERAND: st_nxt.operand = hwdata[W-1:0];
        REG_MEMRES: st_nxt.mem_res = hwdata[W-1:0];
        REG_XREG: st_nxt.xreg = hwdata[15:0]; // [RL18]
        REG_PC: st_nxt.pc = hwdata[15:0]; // [RL18]
        REG_OPBYTES: st_nxt.opbytes = hwdata[15:0];
        REG_CMD: begin
          st_nxt.cmd = hwdata[7:0];
          st_nxt.illegal = !dec_valid; // [RL20]
          if (dec_valid) begin
            st_nxt.exe = EXE_RUN;
            st_nxt.cnt = dec_cycles - CYC_STEP; // [RL11] [RL14]
          end
        end
        default: st_nxt.illegal = st_r.illegal;
      endcase
    end
    unique case (st_r.exe)
      EXE_IDLE: st_nxt.cnt = st_nxt.cnt;
      EXE_RUN: begin
        if (commit) begin
          // result and flags land in the same edge
          st_nxt.flags = alu_flags; // [RL21]
          if (dec_to_mem) begin
            st_nxt.mem_res = alu_res; // [RL12] [RL15]
          end else if (dec_acc_b) begin
            st_nxt.acc2 = alu_res; // [RL19]
          end else begin
            st_nxt.acc1 = alu_res; // [RL7] [RL8] [RL9] [RL10]
          end
          st_nxt.pc = st_r.pc + 16'(dec_bytes);
          st_nxt.exe = EXE_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - CYC_STEP;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r.bus <= BUS_IDLE;
      st_r.idx <= REG_ACC1;
      st_r.wr_ok <= 1'h0;
      st_r.exe <= EXE_IDLE;
      st_r.cnt <= CYC_LAST;
      st_r.acc1 <= BYTE_RST;
      st_r.acc2 <= BYTE_RST;
      st_r.operand <= BYTE_RST;
      st_r.mem_res <= BYTE_RST;
      st_r.cmd <= BYTE_RST;
      st_r.flags <= FLAGS_RST;
      st_r.illegal <= 1'h0;
      st_r.opbytes <= WORD16_RST;
      st_r.xreg <= WORD16_RST;
      st_r.pc <= WORD16_RST;
      st_r.rdata <= WORD_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = (st_r.bus != BUS_RD_WAIT);
  assign hresp = 1'h0;
  assign hrdata = st_r.rdata;
  assign exec_busy = (st_r.exe == EXE_RUN);

  // checks
  logic       f_c;
  logic       f_v;
  logic       f_z;
  logic       f_n;
  logic       f_i;
  logic       f_h;
  logic       is_add;
  logic       is_shift;
  logic       ref_cin;
  logic [8:0] ref_sum;
  logic [4:0] ref_half;
  logic       ref_ovf;
  logic       res_msb;
  logic       a_msb;
  logic       a_lsb;
  logic       rd_start;
  logic [7:0] shl_ind_opc;

  assign f_c = st_r.flags[FLG_C];
  assign f_v = st_r.flags[FLG_V];
  assign f_z = st_r.flags[FLG_Z];
  assign f_n = st_r.flags[FLG_N];
  assign f_i = st_r.flags[FLG_I];
  assign f_h = st_r.flags[FLG_H];
  assign is_add = (dec_op == OP_ADD) || (dec_op == OP_ADC);
  assign is_shift = (dec_op == OP_SHL) || (dec_op == OP_ASR);
  assign ref_cin = (dec_op == OP_ADC) && f_c;
  assign ref_sum = {1'h0, alu_a} + {1'h0, alu_m} + 9'(ref_cin);
  assign ref_half = {1'h0, alu_a[3:0]} + {1'h0, alu_m[3:0]} + 5'(ref_cin);
  assign ref_ovf = (alu_a[7] == alu_m[7]) && (ref_sum[7] != alu_a[7]);
  assign res_msb = alu_res[7];
  assign a_msb = alu_a[7];
  assign a_lsb = alu_a[0];
  assign rd_start = addr_ok && !hwrite && (st_r.bus != BUS_RD_WAIT);
  assign shl_ind_opc = {HI_SH_IND, LO_SHL};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_aba_issue;
    issue && (dec_opc == OPC_ACC_SUM);
  endsequence
  sequence s_run_two;
    exec_busy [*2] ##1 !exec_busy;
  endsequence
  sequence s_run_seven;
    exec_busy [*7] ##1 !exec_busy;
  endsequence
  sequence s_run_four;
    exec_busy [*4] ##1 !exec_busy;
  endsequence
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_aba_timing: assert property (s_aba_issue |=> s_run_two) // [RL7]
    else $error("acc sum did not run two cycles");
  a_shl_ind_time: assert property (issue && (dec_opc == shl_ind_opc) |=> s_run_seven) // [RL14]
    else $error("indexed shift did not run seven cycles");
  a_ext_length: assert property (commit && (dec_mode == MD_EXT) // [RL11]
    |=> st_r.pc == $past(st_r.pc) + 16'(LEN_3))
    else $error("full address mode did not advance three bytes");
  a_zero_flag: assert property (commit |=> f_z == ($past(alu_res) == '0)) // [RL4]
    else $error("zero flag wrong");
  a_neg_flag: assert property (commit && (dec_op != OP_NONE) |=> f_n == $past(res_msb)) // [RL3]
    else $error("negative flag wrong");
  a_carry_out: assert property (commit && is_add |=> f_c == $past(ref_sum[8])) // [RL6]
    else $error("carry flag wrong after addition");
  a_half_carry: assert property (commit && is_add |=> f_h == $past(ref_half[4])) // [RL2]
    else $error("half carry wrong after addition");
  a_add_ovf: assert property (commit && is_add |=> f_v == $past(ref_ovf)) // [RL5]
    else $error("overflow wrong after addition");
  a_and_flags: assert property (commit && (dec_op == OP_AND) // [RL10]
    |=> !f_v && (f_c == $past(f_c)) && (f_h == $past(f_h)))
    else $error("logical and disturbed carry or overflow");
  a_shift_ovf: assert property (commit && is_shift |=> f_v == (f_n ^ f_c)) // [RL13]
    else $error("shift overflow not negative xor carry");
  a_shl_carry: assert property (commit && (dec_op == OP_SHL) |=> f_c == $past(a_msb)) // [RL12]
    else $error("left shift carry not old bit 7");
  a_asr_carry: assert property (commit && (dec_op == OP_ASR) // [RL15]
    |=> (f_c == $past(a_lsb)) && (f_n == $past(a_msb)))
    else $error("signed right shift carry or sign wrong");
  a_mask_kept: assert property (commit |=> f_i == $past(f_i)) // [RL1]
    else $error("interrupt mask changed by datapath");
  a_read_wait: assert property (rd_start |=> s_read_wait)
    else $error("read did not take one wait state");
  a_ext_time: assert property (issue && (dec_mode == MD_EXT) && !dec_to_mem // [RL11]
    |=> s_run_four)
    else $error("full address mode did not run four cycles");
  a_sum_result: assert property (commit && is_add && !dec_acc_b // [RL8] [RL9]
    |=> st_r.acc1 == $past(ref_sum[7:0]))
    else $error("sum not written to first accumulator");
  a_and_result: assert property (commit && (dec_op == OP_AND) && !dec_acc_b // [RL10]
    |=> st_r.acc1 == ($past(alu_a) & $past(alu_m)))
    else $error("logical and result wrong");
  a_illegal_idle: assert property (issue && !dec_valid |=> !exec_busy) // [RL20]
    else $error("undecodable opcode started execution");
endmodule : aal_core

// ### aal_core_test.sv
// self-checking register-level testbench of the accumulator datapath
`timescale 1ns/100ps
module aal_core_test
  import aal_pkg::*;
;
  logic        ref_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        exec_busy;
  int          fails = 0;
  int          checks_done = 0;
  assign hready = hreadyout;
  aal_core #(.W(DATA_W)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .exec_busy(exec_busy));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wait_rdy();
    do begin
      @(posedge ref_clk);
    end while (hready !== 1'b1);
  endtask : wait_rdy
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize  <= SIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : ahb_wr
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize  <= SIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    d = hrdata;
  endtask : ahb_rd
  task automatic wait_idle(output int n);
    n = 0;
    #1;
    while (exec_busy === 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_idle
  // reference result and flags: {result, flags}; kinds 0 add 1 adc 2 and 3 shl 4 asr
  function automatic logic [13:0] model(input int k, input logic [7:0] x, input logic [7:0] y,
                                        input logic [5:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [5:0] o;
    logic       cin;
    o = f;
    cin = (k == 1) & f[FLG_C];
    s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    case (k)
      0, 1: begin
        r = s[7:0];
        o[FLG_H] = h[4];
        o[FLG_C] = s[8];
        o[FLG_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
      end
      2: begin
        r = x & y;
        o[FLG_V] = 1'b0;
      end
      3: begin
        r = {x[6:0], 1'b0};
        o[FLG_C] = x[7];
      end
      default: begin
        r = {x[7], x[7:1]};
        o[FLG_C] = x[0];
      end
    endcase
    o[FLG_N] = r[7];
    o[FLG_Z] = (r == 8'h00);
    if (k >= 3) o[FLG_V] = o[FLG_N] ^ o[FLG_C];
    return {r, o};
  endfunction : model
  // one command with preset registers; dst 0 first acc, 1 second acc, 2 memory result
  task automatic do_cmd(input logic [7:0] opc, input int k, input int dst, input int cyc,
                        input int len, input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] m, input logic [5:0] f);
    logic [31:0] rd;
    logic [13:0] e;
    logic [7:0]  x;
    logic [7:0]  ra;
    int          n;
    x  = (dst == 1) ? b : ((dst == 2) ? m : a);
    ra = (dst == 1) ? REG_ACC2 : ((dst == 2) ? REG_MEMRES : REG_ACC1);
    e  = model(k, x, (opc == OPC_ACC_SUM) ? b : m, f);
    ahb_wr(REG_ACC1, {24'h0, a});
    ahb_wr(REG_ACC2, {24'h0, b});
    ahb_wr(REG_OPERAND, {24'h0, m});
    ahb_wr(REG_FLAGS, {26'h0, f});
    ahb_wr(REG_PC, 32'h0000_1000);
    ahb_wr(REG_CMD, {24'h0, opc});
    wait_idle(n);
    check(32'(n), 32'(cyc), "cycle count");
    ahb_rd(ra, rd);
    check(rd, {24'h0, e[13:6]}, "result");
    ahb_rd(REG_FLAGS, rd);
    check(rd, {26'h0, e[5:0]}, "flags");
    ahb_rd(REG_PC, rd);
    check(rd, 32'h0000_1000 + 32'(len), "length");
  endtask : do_cmd
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  initial begin
    logic [3:0]  hi_d [8] = '{HI_A_IMM, HI_A_DIR, HI_A_EXT, HI_A_IND,
                              HI_B_IMM, HI_B_DIR, HI_B_EXT, HI_B_IND};
    logic [3:0]  lo_d [3] = '{LO_ADC, LO_ADD, LO_AND};
    logic [3:0]  hs_d [4] = '{HI_SH_A, HI_SH_B, HI_SH_EXT, HI_SH_IND};
    logic [3:0]  ls_d [2] = '{LO_SHL, LO_ASR};
    logic [7:0]  xa_d [4] = '{8'h88, 8'h7F, 8'h0F, 8'h80};
    logic [7:0]  xm_d [4] = '{8'h88, 8'h01, 8'hF1, 8'h80};
    int          cy_d [4] = '{2, 3, 4, 5};
    int          ln_d [4] = '{2, 2, 3, 2};
    int          sc_d [4] = '{2, 2, 6, 7};
    int          sl_d [4] = '{1, 1, 3, 2};
    int          sd_d [4] = '{0, 1, 2, 2};
    logic [31:0] rd;
    logic [5:0]  f;
    int          n;
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = SIZE_WORD;
    hwdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check({31'h0, exec_busy}, 32'h0, "busy after reset");
    ahb_rd(REG_FLAGS, rd);
    check(rd, {26'h0, FLAGS_RST}, "flags reset");
    ahb_rd(REG_ACC1, rd);
    check(rd, 32'h0, "acc reset");
    ahb_wr(REG_FLAGS, 32'hFF);
    ahb_rd(REG_FLAGS, rd);
    check(rd, 32'h3F, "flag width");
    ahb_rd(8'h30, rd);
    check(rd, 32'h0, "unmapped read");
    check({31'h0, hresp}, 32'h0, "response");
    do_cmd(OPC_ACC_SUM, 0, 0, 2, 1, 8'h88, 8'h88, 8'h00, 6'h10);
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 3; j++) begin
        f = (j == 0) ? 6'h31 : 6'h10;
        do_cmd({hi_d[i], lo_d[j]}, (j == 0) ? 1 : ((j == 1) ? 0 : 2), i / 4, cy_d[i % 4],
               ln_d[i % 4], xa_d[(i + j) % 4], xa_d[i % 4], xm_d[(i + j) % 4], f);
      end
    end
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        do_cmd({hs_d[i], ls_d[j]}, 3 + j, sd_d[i], sc_d[i], sl_d[i],
               xa_d[i], xm_d[i], xm_d[(i + j + 1) % 4], 6'h21);
      end
    end
    ahb_wr(REG_OPBYTES, 32'h0000_F034);
    do_cmd({HI_A_EXT, LO_ADD}, 0, 0, 4, 3, 8'h01, 8'h02, 8'h03, 6'h00);
    ahb_rd(REG_EA, rd);
    check(rd, 32'hF035_F034, "operand address");
    ahb_wr(REG_PC, 32'h0000_1000);
    ahb_rd(REG_BRANCH, rd);
    check(rd, 32'h0000_0FF2, "branch target");
    ahb_wr(REG_XREG, 32'hABCD_1234);
    ahb_rd(REG_XREG, rd);
    check(rd, 32'h0000_1234, "pointer width");
    do_cmd({HI_A_IND, LO_ADD}, 0, 0, 5, 2, 8'h01, 8'h02, 8'h03, 6'h00);
    ahb_rd(REG_EA, rd);
    check(rd, 32'h1325_1324, "indexed address");
    ahb_wr(REG_ACC1, 32'h11);
    ahb_wr(REG_OPERAND, 32'h40);
    ahb_wr(REG_CMD, {24'h0, HI_SH_IND, LO_SHL});
    ahb_wr(REG_ACC1, 32'h55);
    wait_idle(n);
    ahb_rd(REG_ACC1, rd);
    check(rd, 32'h11, "write while busy");
    ahb_rd(REG_MEMRES, rd);
    check(rd, 32'h80, "memory shift");
    ahb_wr(REG_CMD, 32'h00);
    #1;
    check({31'h0, exec_busy}, 32'h0, "illegal start");
    ahb_rd(REG_STATUS, rd);
    check(rd & 32'h3, 32'h2, "illegal status");
    stop_test();
  end
endmodule : aal_core_test

// ### aal_decode.sv
// opcode decoder of the accumulator datapath
`timescale 1ns/100ps
module aal_decode
  import aal_pkg::*;
(
  // instruction byte
  input  wire logic [7:0] opc,
  // decoded fields
  output logic            valid,
  output aal_op_t         op,
  output logic            acc_b,
  output logic            use_acc2,
  output aal_mode_t       mode,
  output logic            to_mem,
  output logic [1:0]      nbytes,
  output logic [2:0]      ncycles
);
  always_comb begin
    valid = 1'h0;
    op = OP_NONE;
    acc_b = 1'h0;
    use_acc2 = 1'h0;
    mode = MD_INH;
    to_mem = 1'h0;
    if (opc == OPC_ACC_SUM) begin // [RL7]
      valid = 1'h1;
      op = OP_ADD;
      use_acc2 = 1'h1;
    end else begin // [RL20]
      case (opc[3:0])
        LO_ADC, LO_ADD, LO_AND: begin
          op = (opc[3:0] == LO_ADC) ? OP_ADC : (opc[3:0] == LO_ADD) ? OP_ADD : OP_AND;
          valid = 1'h1;
          acc_b = opc[6];
          case (opc[7:4])
            HI_A_IMM, HI_B_IMM: mode = MD_IMM;
            HI_A_DIR, HI_B_DIR: mode = MD_DIR;
            HI_A_EXT, HI_B_EXT: mode = MD_EXT;
            HI_A_IND, HI_B_IND: mode = MD_IND;
            default: valid = 1'h0;
          endcase
        end
        LO_SHL, LO_ASR: begin
          op = (opc[3:0] == LO_SHL) ? OP_SHL : OP_ASR;
          valid = 1'h1;
          case (opc[7:4])
            HI_SH_A: acc_b = 1'h0;
            HI_SH_B: acc_b = 1'h1;
            HI_SH_EXT: begin mode = MD_EXT; to_mem = 1'h1; end
            HI_SH_IND: begin mode = MD_IND; to_mem = 1'h1; end
            default: valid = 1'h0;
          endcase
        end
        default: valid = 1'h0;
      endcase
      if (!valid) begin
        op = OP_NONE;
      end
    end
    unique case (mode) // [RL11] [RL14]
      MD_INH: begin nbytes = LEN_1; ncycles = CYC_INH; end
      MD_IMM: begin nbytes = LEN_2; ncycles = CYC_IMM; end
      MD_DIR: begin nbytes = LEN_2; ncycles = CYC_DIR; end
      MD_EXT: begin nbytes = LEN_3; ncycles = to_mem ? CYC_SH_EXT : CYC_EXT; end
      MD_IND: begin nbytes = LEN_2; ncycles = to_mem ? CYC_SH_IND : CYC_IND; end
      default: begin nbytes = LEN_1; ncycles = CYC_INH; end
    endcase
  end
endmodule : aal_decode

// ### aal_pkg.sv
// shared constants and types of the accumulator datapath
package aal_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  // condition flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam int FLG_W = 6;
  localparam int HALF_BIT = 3;
  localparam logic [FLG_W-1:0] FLAGS_RST = 6'h00;
  // opcodes and opcode nibbles
  localparam logic [7:0] OPC_ACC_SUM = 8'h1B;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ADD = 4'hB;
  localparam logic [3:0] LO_AND = 4'h4;
  localparam logic [3:0] LO_SHL = 4'h8;
  localparam logic [3:0] LO_ASR = 4'h7;
  localparam logic [3:0] HI_A_IMM = 4'h8;
  localparam logic [3:0] HI_A_DIR = 4'h9;
  localparam logic [3:0] HI_A_EXT = 4'hB;
  localparam logic [3:0] HI_A_IND = 4'hA;
  localparam logic [3:0] HI_B_IMM = 4'hC;
  localparam logic [3:0] HI_B_DIR = 4'hD;
  localparam logic [3:0] HI_B_EXT = 4'hF;
  localparam logic [3:0] HI_B_IND = 4'hE;
  localparam logic [3:0] HI_SH_A = 4'h4;
  localparam logic [3:0] HI_SH_B = 4'h5;
  localparam logic [3:0] HI_SH_EXT = 4'h7;
  localparam logic [3:0] HI_SH_IND = 4'h6;
  // cycle counts and instruction lengths
  localparam logic [2:0] CYC_INH = 3'h2;
  localparam logic [2:0] CYC_IMM = 3'h2;
  localparam logic [2:0] CYC_DIR = 3'h3;
  localparam logic [2:0] CYC_EXT = 3'h4;
  localparam logic [2:0] CYC_IND = 3'h5;
  localparam logic [2:0] CYC_SH_EXT = 3'h6;
  localparam logic [2:0] CYC_SH_IND = 3'h7;
  localparam logic [2:0] CYC_LAST = 3'h0;
  localparam logic [2:0] CYC_STEP = 3'h1;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  // address arithmetic and reset values
  localparam logic [15:0] NEXT_BYTE = 16'h0001;
  localparam logic [15:0] BRANCH_STEP = 16'h0002;
  localparam logic [15:0] WORD16_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_ACC1 = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ACC2 = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OPERAND = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MEMRES = 8'h18;
  localparam logic [ADDR_W-1:0] REG_XREG = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_PC = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OPBYTES = 8'h24;
  localparam logic [ADDR_W-1:0] REG_EA = 8'h28;
  localparam logic [ADDR_W-1:0] REG_BRANCH = 8'h2C;
  // status fields and bus codes
  localparam int ST_BUSY = 0;
  localparam int ST_ILLEGAL = 1;
  localparam int ST_CYC_LSB = 4;
  localparam int ST_LEN_LSB = 8;
  localparam int HTRANS_ACT = 1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  typedef enum logic [2:0] {OP_NONE = 3'b000, OP_ADD = 3'b001, OP_ADC = 3'b010,
                            OP_AND = 3'b011, OP_SHL = 3'b100, OP_ASR = 3'b101} aal_op_t;
  typedef enum logic [2:0] {MD_INH = 3'b000, MD_IMM = 3'b001, MD_DIR = 3'b010,
                            MD_IND = 3'b011, MD_EXT = 3'b100} aal_mode_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_WR = 2'b01, BUS_RD_WAIT = 2'b10,
                            BUS_RD_DONE = 2'b11} aal_bus_t;
  typedef enum logic {EXE_IDLE = 1'b0, EXE_RUN = 1'b1} aal_exe_t;
endpackage : aal_pkg
